/* verilog/fcp_pkg.sv */
package fcp_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_PROTECT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_COMMAND = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;

  // Configuration fields and reset value
  localparam int CFG_KEY_ENABLE_BIT = 5;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hE0;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // Protection fields
  localparam int PROT_DISABLE_BIT = 0;
  localparam logic [8:0] PROT_PAGE_FILL = 9'h1FF;

  // Status fields and the bits that always read zero
  localparam int ST_BUF_EMPTY_BIT = 7;
  localparam int ST_COMPLETE_BIT = 6;
  localparam int ST_VIOLATION_BIT = 5;
  localparam int ST_ACCESS_ERR_BIT = 4;
  localparam int ST_BLANK_BIT = 2;
  localparam logic [7:0] ST_ZERO_MASK = 8'h0B;

  // Interrupt status layout, shared by clear and enable
  localparam int IRQ_COMPLETE_BIT = 0;
  localparam int IRQ_VIOLATION_BIT = 1;
  localparam int IRQ_ACCESS_ERR_BIT = 2;
  localparam logic [2:0] IRQ_ENABLE_RESET = 3'h0;

  // Backdoor key address window
  localparam logic [15:0] KEY_ADDR_LOW = 16'hFFB0;
  localparam logic [15:0] KEY_ADDR_HIGH = 16'hFFB7;

  // Command codes
  localparam logic [7:0] CMD_BLANK_CHECK = 8'h05;
  localparam logic [7:0] CMD_BYTE_PROGRAM = 8'h20;
  localparam logic [7:0] CMD_BURST_PROGRAM = 8'h25;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h40;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h41;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } fcp_flash_wr_s;

  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] addr;
    logic [7:0] data;
  } fcp_array_req_s;

endpackage

/* verilog/fcp_sync2.sv */
`timescale 1ns/100ps
// Two-stage synchroniser for a level from outside the clock domain
module fcp_sync2 (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic d,
  output logic q
);
  logic meta;

  // First stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

/* verilog/fcp_sticky.sv */
`timescale 1ns/100ps
// Sticky flag; a set in the clearing cycle wins
module fcp_sticky (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic set,
  input wire logic clr,
  output logic q
);
  logic next_q;

  // Set has priority so no event is lost
  always_comb begin
    next_q = set ? 1'b1 : (clr ? 1'b0 : q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= 1'b0;
    end else begin
      q <= next_q;
    end
  end
endmodule

/* verilog/fcp_top.sv */
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
// Functional notes
// R1: Config bits 7..5 are read/write at any time; bits 4..0 read zero and ignore writes.
// R2: With key compare disabled, a write in the key window starts a program/erase sequence.
// R3: With key compare enabled, key window writes go to key compare and flash reads are invalid.
// R4: During reset the stored protection byte is copied into the protection register.
// R5: Protection reads any time, ignores user writes, accepts background debug writes.
// R6: With protection on, the boundary field ends the unprotected region; protected targets refuse.
// R7: Protect-disable zero protects the selected block; one protects nothing.
// R8: Status bits 3, 1 and 0 read zero and ignore writes.
// R9: Writing one to buffer-empty launches a command and clears it; a burst hand-off sets it again.
// R10: Only burst program is buffered; buffer-empty set means another burst may be written.
// R11: Complete sets when buffer empty and idle, clears on launch, ignores writes.
// R12: A launch onto a protected location sets violation and is dropped; writing one clears it.
// R13: Bad sequence, program/erase before divider setup, or stop mid-command set access error.
// R14: A blank check over an erased array sets blank; a valid launch clears it; writes ignored.
// R15: Only codes 05, 20, 25, 40 and 41 are legal; any other is an access error.
// R16: After reset buffer-empty and complete are set, the other flags clear.
module fcp_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] stored_protection_byte,
  input wire logic bdm_prot_we,
  input wire logic [7:0] bdm_prot_data,
  input wire logic divider_initialized,
  input wire logic stop_entry,
  input wire logic flash_wr_valid,
  input wire fcp_pkg::fcp_flash_wr_s flash_wr,
  output logic key_wr_valid,
  output fcp_pkg::fcp_flash_wr_s key_wr,
  output logic flash_read_invalid,
  output logic array_start,
  output fcp_pkg::fcp_array_req_s array_req,
  output logic array_abort,
  input wire logic array_done,
  input wire logic array_blank_ok,
  output logic irq
);
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_HAVE_WRITE, SEQ_HAVE_CMD} fcp_seq_e;

  // Bus slave state
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [7:0] awaddr_q, next_awaddr;
  logic [7:0] wdata_q, next_wdata;
  logic wlane_q, next_wlane;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic wr_fire, wr_lane, wr_mapped;
  logic wr_cfg, wr_stat, wr_cmd, wr_iclr, wr_ien;

  // Block state
  logic [7:0] cfg, next_cfg, prot, next_prot;
  logic cbef, next_cbef, ccf, next_ccf, blank, next_blank;
  logic pviol, accerr;
  fcp_seq_e seq, next_seq;
  fcp_pkg::fcp_flash_wr_s lat, next_lat;
  logic [7:0] lat_cmd, next_lat_cmd;
  fcp_pkg::fcp_array_req_s buf_req, next_buf_req, next_array_req;
  logic buf_valid, next_buf_valid, running, next_running;
  logic next_array_start, next_array_abort, next_key_wr_valid, next_flash_read_invalid;
  logic key_hit, step_wr, launch_ok, pv_set, acc_set, stop_s;
  logic [2:0] irq_stat, irq_en, next_irq_en, irq_ev;
  logic next_irq;

  // Legal command codes
  function automatic logic legal_cmd(input logic [7:0] c);
    return c == fcp_pkg::CMD_BLANK_CHECK || c == fcp_pkg::CMD_BYTE_PROGRAM ||
           c == fcp_pkg::CMD_BURST_PROGRAM || c == fcp_pkg::CMD_PAGE_ERASE ||
           c == fcp_pkg::CMD_MASS_ERASE;
  endfunction

  // Protected target check; mass erase hits any protected block
  function automatic logic prot_hit(input logic [7:0] p, input logic [7:0] c,
                                    input logic [15:0] a);
    if (p[fcp_pkg::PROT_DISABLE_BIT] || c == fcp_pkg::CMD_BLANK_CHECK) begin // R7
      return 1'b0;
    end
    if (c == fcp_pkg::CMD_MASS_ERASE) begin
      return 1'b1;
    end
    return a > {p[7:1], fcp_pkg::PROT_PAGE_FILL}; // R6
  endfunction

  fcp_sync2 u_stop_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(stop_entry),
    .q(stop_s)
  );

  // Write strobes; only byte lane 0 carries register data
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_lane = wr_fire && wlane_q;
  assign wr_mapped = awaddr_q <= fcp_pkg::ADDR_IRQ_ENABLE && awaddr_q[1:0] == 2'h0;
  assign wr_cfg = wr_lane && awaddr_q == fcp_pkg::ADDR_CONFIG;
  assign wr_stat = wr_lane && awaddr_q == fcp_pkg::ADDR_STATUS;
  assign wr_cmd = wr_lane && awaddr_q == fcp_pkg::ADDR_COMMAND;
  assign wr_iclr = wr_lane && awaddr_q == fcp_pkg::ADDR_IRQ_CLEAR;
  assign wr_ien = wr_lane && awaddr_q == fcp_pkg::ADDR_IRQ_ENABLE;

  // AXI4-Lite channels: address and data taken in either order
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_awaddr = awaddr_q;
    next_wdata = wdata_q;
    next_wlane = wlane_q;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_wdata = s_axi_wdata[7:0];
      next_wlane = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_mapped ? fcp_pkg::RESP_OKAY : fcp_pkg::RESP_SLVERR;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = fcp_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        fcp_pkg::ADDR_CONFIG: next_rdata = {24'h000000, cfg};
        fcp_pkg::ADDR_PROTECT: next_rdata = {24'h000000, prot};
        fcp_pkg::ADDR_STATUS: next_rdata = {24'h000000, cbef, ccf, pviol, accerr,
                                            1'b0, blank, 2'h0}; // R8
        fcp_pkg::ADDR_COMMAND: next_rdata = {24'h000000, lat_cmd};
        fcp_pkg::ADDR_IRQ_STATUS: next_rdata = {29'h0, irq_stat};
        fcp_pkg::ADDR_IRQ_CLEAR: next_rdata = 32'h00000000;
        fcp_pkg::ADDR_IRQ_ENABLE: next_rdata = {29'h0, irq_en};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = fcp_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_awready = !next_aw_held;
    next_wready = !next_w_held;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= fcp_pkg::RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= fcp_pkg::RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awaddr_q <= next_awaddr;
      wdata_q <= next_wdata;
      wlane_q <= next_wlane;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // Flash-space writes: key compare or first step of a command
  assign key_hit = flash_wr_valid && cfg[fcp_pkg::CFG_KEY_ENABLE_BIT] &&
                   flash_wr.addr >= fcp_pkg::KEY_ADDR_LOW &&
                   flash_wr.addr <= fcp_pkg::KEY_ADDR_HIGH; // R3
  assign step_wr = flash_wr_valid && !key_hit; // R2

  // Command sequencer, buffer and flags
  always_comb begin
    next_cfg = wr_cfg ? (wdata_q & fcp_pkg::CFG_WRITE_MASK) : cfg; // R1
    next_prot = bdm_prot_we ? bdm_prot_data : prot; // R5
    next_seq = seq;
    next_lat = lat;
    next_lat_cmd = lat_cmd;
    next_buf_req = buf_req;
    next_buf_valid = buf_valid;
    next_running = running;
    next_array_req = array_req;
    next_array_start = 1'b0;
    next_array_abort = 1'b0;
    next_cbef = cbef;
    next_blank = blank;
    launch_ok = 1'b0;
    pv_set = 1'b0;
    acc_set = 1'b0;
    next_key_wr_valid = key_hit;
    next_flash_read_invalid = next_cfg[fcp_pkg::CFG_KEY_ENABLE_BIT]; // R3
    if (step_wr) begin
      if (seq == SEQ_IDLE && cbef) begin
        next_seq = SEQ_HAVE_WRITE; // R2
        next_lat = flash_wr;
      end else begin
        acc_set = 1'b1; // R13
        next_seq = SEQ_IDLE;
      end
    end
    if (wr_cmd) begin
      if (seq == SEQ_HAVE_WRITE && legal_cmd(wdata_q)) begin
        next_seq = SEQ_HAVE_CMD;
        next_lat_cmd = wdata_q;
      end else begin
        acc_set = 1'b1; // R15
        next_seq = SEQ_IDLE;
      end
    end
    // Launch attempt; an ignored command leaves buffer-empty set
    if (wr_stat && wdata_q[fcp_pkg::ST_BUF_EMPTY_BIT] && cbef) begin
      next_seq = SEQ_IDLE;
      if (seq != SEQ_HAVE_CMD) begin
        acc_set = 1'b1; // R13
      end else if (!divider_initialized && lat_cmd != fcp_pkg::CMD_BLANK_CHECK) begin
        acc_set = 1'b1; // R13
      end else if (prot_hit(prot, lat_cmd, lat.addr)) begin
        pv_set = 1'b1; // R12
      end else begin
        launch_ok = 1'b1;
      end
    end
    // Array finished; a launch in the same cycle clears the blank result
    if (array_done && running) begin
      next_running = 1'b0;
      if (array_req.cmd == fcp_pkg::CMD_BLANK_CHECK && array_blank_ok) begin
        next_blank = 1'b1; // R14
      end
      if (!buf_valid) begin
        next_cbef = 1'b1;
      end
    end
    // Buffer hand-off; a burst frees the buffer at once
    if (buf_valid && !running) begin
      next_array_start = 1'b1;
      next_array_req = buf_req;
      next_running = 1'b1;
      next_buf_valid = 1'b0;
      if (buf_req.cmd == fcp_pkg::CMD_BURST_PROGRAM) begin
        next_cbef = 1'b1; // R10
      end
    end
    if (launch_ok) begin
      next_buf_valid = 1'b1;
      next_buf_req = '{cmd: lat_cmd, addr: lat.addr, data: lat.data};
      next_cbef = 1'b0; // R9
      next_blank = 1'b0; // R14
    end
    // Stop during a command kills it and flags the error
    if (stop_s && (running || buf_valid)) begin
      acc_set = 1'b1; // R13
      next_buf_valid = 1'b0;
      next_running = 1'b0;
      next_array_abort = running;
      next_cbef = 1'b1;
    end
    if (launch_ok) begin
      next_ccf = 1'b0; // R11
    end else if (!buf_valid && !running) begin
      next_ccf = 1'b1; // R11
    end else begin
      next_ccf = ccf;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= fcp_pkg::CFG_RESET;
      prot <= stored_protection_byte; // R4
      seq <= SEQ_IDLE;
      lat <= '0;
      lat_cmd <= 8'h00;
      buf_req <= '0;
      buf_valid <= 1'b0;
      running <= 1'b0;
      array_req <= '0;
      array_start <= 1'b0;
      array_abort <= 1'b0;
      cbef <= 1'b1; // R16
      ccf <= 1'b1; // R16
      blank <= 1'b0;
      key_wr_valid <= 1'b0;
      key_wr <= '0;
      flash_read_invalid <= 1'b0;
    end else begin
      cfg <= next_cfg;
      prot <= next_prot;
      seq <= next_seq;
      lat <= next_lat;
      lat_cmd <= next_lat_cmd;
      buf_req <= next_buf_req;
      buf_valid <= next_buf_valid;
      running <= next_running;
      array_req <= next_array_req;
      array_start <= next_array_start;
      array_abort <= next_array_abort;
      cbef <= next_cbef;
      ccf <= next_ccf;
      blank <= next_blank;
      key_wr_valid <= next_key_wr_valid;
      key_wr <= flash_wr;
      flash_read_invalid <= next_flash_read_invalid;
    end
  end

  // Write-one-to-clear error flags
  fcp_sticky u_pviol (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(pv_set),
    .clr(wr_stat && wdata_q[fcp_pkg::ST_VIOLATION_BIT]), // R12
    .q(pviol)
  );

  fcp_sticky u_accerr (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(acc_set),
    .clr(wr_stat && wdata_q[fcp_pkg::ST_ACCESS_ERR_BIT]), // R13
    .q(accerr)
  );

  // Interrupt events: completion edge, violation, access error
  always_comb begin
    irq_ev = 3'h0;
    irq_ev[fcp_pkg::IRQ_COMPLETE_BIT] = next_ccf && !ccf;
    irq_ev[fcp_pkg::IRQ_VIOLATION_BIT] = pv_set;
    irq_ev[fcp_pkg::IRQ_ACCESS_ERR_BIT] = acc_set;
    next_irq_en = wr_ien ? wdata_q[2:0] : irq_en;
    next_irq = |(irq_stat & irq_en);
  end

  for (genvar i = 0; i < 3; i++) begin : g_irq
    fcp_sticky u_flag (
      .aclk(aclk),
      .aresetn(aresetn),
      .set(irq_ev[i]),
      .clr(wr_iclr && wdata_q[i]),
      .q(irq_stat[i])
    );
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en <= fcp_pkg::IRQ_ENABLE_RESET;
      irq <= 1'b0;
    end else begin
      irq_en <= next_irq_en;
      irq <= next_irq;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_burst_ready;
    buf_valid && !running && buf_req.cmd == fcp_pkg::CMD_BURST_PROGRAM && !stop_s;
  endsequence
  sequence s_blank_pass;
    array_done && running && array_req.cmd == fcp_pkg::CMD_BLANK_CHECK && array_blank_ok;
  endsequence

  a_cfg_write_mask: assert property (wr_cfg |=> cfg == ($past(wdata_q) & 8'hE0)) // R1
    else $error("config write not masked");
  a_key_off_step: assert property (step_wr && !cfg[5] && seq == SEQ_IDLE && cbef
    |=> seq == SEQ_HAVE_WRITE && !key_wr_valid) // R2
    else $error("key window write did not start a sequence");
  a_key_on_route: assert property (key_hit |=> key_wr_valid && flash_read_invalid) // R3
    else $error("key compare write not routed");
  a_prot_reset_load: assert property (@(posedge aclk) $rose(aresetn)
    |-> prot == $past(stored_protection_byte) && cbef && ccf && !pviol && !blank) // R4
    else $error("reset values wrong");
  a_prot_user_ro: assert property (wr_fire && awaddr_q == fcp_pkg::ADDR_PROTECT
    && !bdm_prot_we |=> $stable(prot)) // R5
    else $error("user write changed protection");
  a_prot_refuse: assert property (pv_set |=> pviol && !buf_valid ##1 !array_start) // R6
    else $error("protected command not dropped");
  a_prot_disabled: assert property (prot[0] |-> !pv_set) // R7
    else $error("violation with protection disabled");
  a_stat_zero_bits: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == fcp_pkg::ADDR_STATUS |=> (s_axi_rdata[7:0] & 8'h0B) == 8'h00) // R8
    else $error("status reserved bits not zero");
  a_launch_flags: assert property (launch_ok && !stop_s |=> !cbef && !ccf && buf_valid) // R9
    else $error("launch did not clear flags");
  a_burst_handoff: assert property (s_burst_ready |=> array_start && cbef) // R10
    else $error("burst hand-off wrong");
  a_complete_idle: assert property (!buf_valid && !running && !launch_ok |=> ccf) // R11
    else $error("complete flag not set while idle");
  a_bad_code: assert property (wr_cmd && !legal_cmd(wdata_q) |=> accerr
    && seq == SEQ_IDLE) // R15
    else $error("illegal code not flagged");
  a_stop_abort: assert property (stop_s && running |=> accerr && array_abort
    && !running) // R13
    else $error("stop during command not flagged");
  a_blank_set: assert property ((s_blank_pass and !launch_ok) |=> blank) // R14
    else $error("blank flag not set");
endmodule

/* tb/fcp_array_model.sv */
`timescale 1ns/100ps
// Flash array stand-in: answers each start after a short or a long busy time
module fcp_array_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic array_start,
  input wire fcp_pkg::fcp_array_req_s array_req,
  input wire logic slow,
  input wire logic blank,
  output logic array_done,
  output logic array_blank_ok
);
  int cnt;
  initial array_blank_ok = 1'h0;
  // Blank result means nothing outside done, so it toggles there
  always @(posedge aclk) begin
    array_done <= 1'h0;
    array_blank_ok <= ~array_blank_ok;
    if (!aresetn) begin
      cnt <= 0;
    end else if (array_start) begin
      cnt <= slow ? 20 : 4;
    end else if (cnt == 1) begin
      array_done <= 1'h1;
      array_blank_ok <= blank && (array_req.cmd == fcp_pkg::CMD_BLANK_CHECK);
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

/* tb/fcp_top_test.sv */
`timescale 1ns/100ps
module fcp_top_test;
  localparam logic [7:0] ST = fcp_pkg::ADDR_STATUS;
  localparam logic [7:0] CF = fcp_pkg::ADDR_CONFIG;
  localparam logic [7:0] PR = fcp_pkg::ADDR_PROTECT;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [7:0] stored_protection_byte = 8'h80, bdm_prot_data = '0;
  logic bdm_prot_we = 1'h0, divider_initialized = 1'h1, stop_entry = 1'h0;
  logic flash_wr_valid = 1'h0, slow = 1'h0, blank = 1'h0;
  fcp_pkg::fcp_flash_wr_s flash_wr = '0, key_wr;
  fcp_pkg::fcp_array_req_s array_req;
  logic key_wr_valid, flash_read_invalid, array_start, array_abort, array_done;
  logic array_blank_ok, irq;
  int n_fail = 0, n_tests = 0, cyc = 0;
  logic [7:0] codes [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
  logic [7:0] after [5] = '{8'hC0, 8'hC0, 8'hC0, 8'hC0, 8'hE0};

  fcp_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .stored_protection_byte, .bdm_prot_we, .bdm_prot_data, .divider_initialized,
    .stop_entry, .flash_wr_valid, .flash_wr, .key_wr_valid, .key_wr, .flash_read_invalid,
    .array_start, .array_req, .array_abort, .array_done, .array_blank_ok, .irq);
  fcp_array_model array_side (.aclk, .aresetn, .array_start, .array_req, .slow, .blank,
    .array_done, .array_blank_ok);

  initial forever #10 aclk = ~aclk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Write master: both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int k;
    logic done;
    k = 0;
    done = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!done && k < 100) begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) s_axi_bready <= 1'h0;
      done = s_axi_bvalid;
    end
    if (!done) n_fail++;
  endtask

  task automatic rdx(input logic [7:0] a);
    int k;
    logic done;
    k = 0;
    done = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!done && k < 100) begin
      @(posedge aclk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) s_axi_rready <= 1'h0;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      done = s_axi_rvalid;
    end
    if (!done) n_fail++;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
    rdx(a);
    chk(nm, rd, {24'h0, exp});
  endtask

  // Irq is registered one cycle after the status it follows
  task automatic ichk(input logic exp);
    repeat (2) @(posedge aclk);
    #1 chk("irq", irq, exp);
  endtask

  task automatic step(input logic [15:0] a);
    @(posedge aclk);
    flash_wr_valid <= 1'h1;
    flash_wr <= '{a, 8'h5A};
    @(posedge aclk);
    flash_wr_valid <= 1'h0;
  endtask

  task automatic run(input logic [15:0] a, input logic [7:0] c);
    step(a);
    wr(fcp_pkg::ADDR_COMMAND, c);
    wr(ST, 8'h80);
  endtask

  // Poll with a bound until the complete flag comes back
  task automatic idle();
    int k;
    k = 0;
    rdx(ST);
    while (rd[6] !== 1'h1 && k < 60) begin
      rdx(ST);
      k++;
    end
  endtask

  task automatic t_reset();
    rchk(CF, 8'h00, "config reset");
    rchk(PR, 8'h80, "prot reset");
    rchk(ST, 8'hC0, "status reset");
    rdx(8'h1C);
    chk("unmapped resp", rr, fcp_pkg::RESP_SLVERR);
    wr(CF, 8'hFF);
    rchk(CF, 8'hE0, "config mask");
    wr(ST, 8'h0F);
    rchk(ST, 8'hC0, "status zero bits");
  endtask

  task automatic t_key();
    wr(CF, 8'h20);
    step(16'hFFB3);
    #1 chk("key valid", key_wr_valid, 1'h1);
    chk("key addr", key_wr.addr, 16'hFFB3);
    chk("read invalid", flash_read_invalid, 1'h1);
    rchk(ST, 8'hC0, "key no cmd");
    wr(CF, 8'h00);
    step(16'hFFB3);
    #1 chk("key off", key_wr_valid, 1'h0);
    wr(fcp_pkg::ADDR_COMMAND, fcp_pkg::CMD_BYTE_PROGRAM);
    wr(ST, 8'h80);
    idle();
    chk("key window cmd", rd, 32'hE0);
    wr(ST, 8'h20);
    rchk(ST, 8'hC0, "viol w1c");
  endtask

  task automatic t_irq();
    wr(fcp_pkg::ADDR_IRQ_CLEAR, 8'h07);
    wr(fcp_pkg::ADDR_IRQ_ENABLE, 8'h01);
    ichk(1'h0);
    run(16'h1000, fcp_pkg::CMD_BYTE_PROGRAM);
    rchk(ST, 8'h00, "launched");
    chk("req cmd", array_req.cmd, fcp_pkg::CMD_BYTE_PROGRAM);
    idle();
    chk("done status", rd, 32'hC0);
    ichk(1'h1);
    wr(fcp_pkg::ADDR_IRQ_ENABLE, 8'h00);
    ichk(1'h0);
    wr(fcp_pkg::ADDR_IRQ_ENABLE, 8'h01);
    ichk(1'h1);
    wr(fcp_pkg::ADDR_IRQ_CLEAR, 8'h01);
    ichk(1'h0);
    rchk(fcp_pkg::ADDR_IRQ_CLEAR, 8'h00, "clear reads 0");
  endtask

  task automatic t_blank();
    blank = 1'h1;
    run(16'h0000, fcp_pkg::CMD_BLANK_CHECK);
    idle();
    chk("blank set", rd, 32'hC4);
    wr(ST, 8'h0F);
    rchk(ST, 8'hC4, "blank hold");
    blank = 1'h0;
    slow = 1'h1;
    run(16'h1000, fcp_pkg::CMD_BURST_PROGRAM);
    rchk(ST, 8'h80, "burst buffered");
    idle();
    chk("blank cleared", rd, 32'hC0);
    slow = 1'h0;
  endtask

  // Every legal code, then codes outside the set
  task automatic t_codes();
    for (int i = 0; i < 5; i++) begin
      run(16'h1000, codes[i]);
      idle();
      chk("legal code", rd, {24'h0, after[i]});
      wr(ST, 8'h20);
    end
    for (int i = 0; i < 3; i++) begin
      run(16'h1000, 8'h21 + 8'(i * 8'h5F));
      idle();
      chk("bad code", rd, 32'hD0);
      wr(ST, 8'h10);
    end
    divider_initialized <= 1'h0;
    run(16'h1000, fcp_pkg::CMD_PAGE_ERASE);
    idle();
    chk("no divider", rd, 32'hD0);
    wr(ST, 8'h00);
    rchk(ST, 8'hD0, "w0 no effect");
    wr(ST, 8'h10);
    divider_initialized <= 1'h1;
  endtask

  task automatic t_bdm();
    wr(PR, 8'hFF);
    rchk(PR, 8'h80, "prot ro");
    @(posedge aclk);
    bdm_prot_we <= 1'h1;
    bdm_prot_data <= 8'h01;
    @(posedge aclk);
    bdm_prot_we <= 1'h0;
    rchk(PR, 8'h01, "prot bdm");
    run(16'hC000, fcp_pkg::CMD_MASS_ERASE);
    idle();
    chk("unprotected", rd, 32'hC0);
  endtask

  // Stop mid-command, then a second reset that reloads protection
  task automatic t_stop();
    int k;
    k = 0;
    slow = 1'h1;
    wr(fcp_pkg::ADDR_IRQ_CLEAR, 8'h07);
    run(16'h1000, fcp_pkg::CMD_BYTE_PROGRAM);
    stop_entry <= 1'h1;
    @(posedge aclk);
    while (!array_abort && k < 10) begin
      @(posedge aclk);
      k++;
    end
    chk("abort", array_abort, 1'h1);
    stop_entry <= 1'h0;
    idle();
    chk("stop error", rd, 32'hD0);
    rchk(fcp_pkg::ADDR_IRQ_STATUS, 8'h05, "irq events");
    stored_protection_byte <= 8'h42;
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rchk(PR, 8'h42, "prot reload");
    rchk(ST, 8'hC0, "status reload");
    slow = 1'h0;
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard well above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_key();
    t_irq();
    t_blank();
    t_codes();
    t_bdm();
    t_stop();
    tally_and_finish();
  end
endmodule
